//--- wind_cmd_handler.sv
// Purpose: Register-driven command interpreter for wind sensor settings
// Assumes: a serial front end parses frames and writes code, level, parameter
// Notes: One command is executed per write of the command register
// Function
// - Direction swap 0 normal, 1 inverted, default 0; swaps east and west.
// - East and north delays hold 0 to FFFh, default 0, factory only.
// - South and west delays hold 0 to 4096, default 0, factory only.
// - Converter kind 0 or 1, config mode, initial value instrument dependent.
// - Telegram request 1 to 16 sends the selected telegram once.
// - Telegram numbers map to fixed layouts; 10, 11, 13, 15 reserved.
// - Reply starts less than one millisecond after the request.
// - Auto output 0 to 16, default 0, sent every output interval; skipped if a telegram request executes that cycle.
// - Append adds one definition at the user telegram end.
// - Text buffer of 32 entries of 32 characters, index 1 to 32.
// - Drop removes 0 to 30 definitions from the user telegram end.
// - Edits stay volatile; save with parameter 2 writes nonvolatile store.
// - Define overwrites any existing user telegram definition.
// - User telegram is number 6 by request and by auto output.
// - Speed factor per mil, 0 to 2000, default 1055.
// - Angle correction 0 off, 1 standard, 2 encapsulated, default 2.
// - External ID from three lines, bits 0 to 2, else stored ID.
// - ID lines active low: 0 V gives bit one.
// - With external ID, sample at start-up, store, and announce it.
// - Access levels gate each command as configuration, user or enquiry.
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module wind_cmd_handler #(
	parameter int MS_CYCLES = wind_cmd_pkg::CYCLES_PER_MS,
	parameter logic CONV_KIND_INIT = 1'b0,
	parameter int ITEM_W = 6
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// External ID lines, active low
	input wire logic speed_out_rx_neg_line_n,
	input wire logic dir_out_rx_pos_line_n,
	input wire logic third_id_line_n,
	// Nonvolatile values presented at start-up
	input wire logic nv_pin_id_sel,
	input wire logic [2:0] nv_instrument_id,
	// Telegram transmitter
	output logic telegram_send,
	output logic [4:0] telegram_num,
	// Nonvolatile store requests
	output logic nv_id_write,
	output logic id_announce,
	output logic nv_telegram_save,
	output logic [ITEM_W-1:0] nv_item_count,
	// Settings to the measurement path
	output logic [2:0] instrument_id,
	output logic direction_swap,
	output logic converter_kind,
	output logic [11:0] east_delay,
	output logic [11:0] north_delay,
	output logic [12:0] south_delay,
	output logic [12:0] west_delay,
	output logic [10:0] speed_factor,
	output logic [1:0] angle_corr
);
	typedef enum logic [1:0] {ST_BOOT, ST_ANNOUNCE, ST_RUN} boot_e;

	boot_e boot_q;
	logic wr_pend_q;
	logic rd_en;
	logic [7:0] addr_q;
	logic [15:0] param_q;
	logic exec;
	logic [4:0] code;
	logic [1:0] level;
	logic [1:0] need;
	logic ok;
	logic accepted_q;
	logic rejected_q;
	logic [4:0] auto_sel_q;
	logic pin_id_sel_q;
	logic [ITEM_W-1:0] items_q;
	logic [5:0] text_idx_q;
	logic [4:0] text_pos_q;
	logic [9:0] text_raddr_q;
	logic [7:0] text_rdata;
	logic text_we;
	logic [15:0] interval_q;
	logic [31:0] ms_cnt_q;
	logic ms_tick;
	logic [15:0] ivl_cnt_q;
	logic [2:0] pin_id;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rd_en = hsel && hready && htrans[1] && !hwrite;
	assign exec = wr_pend_q && addr_q == wind_cmd_pkg::CMD_OFF && boot_q == ST_RUN;
	assign code = hwdata[wind_cmd_pkg::CMD_CODE_LSB +: 5];
	assign level = hwdata[wind_cmd_pkg::CMD_LEVEL_LSB +: 2];
	assign pin_id = {~third_id_line_n, ~dir_out_rx_pos_line_n, ~speed_out_rx_neg_line_n};

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite;
			addr_q <= haddr[7:0];
		end
	end

	always_comb begin
		need = wind_cmd_pkg::LEVEL_ENQUIRY;
		unique case (code)
			wind_cmd_pkg::DIRECTION_SWAP_CMD, wind_cmd_pkg::EAST_DELAY_CMD, wind_cmd_pkg::NORTH_DELAY_CMD,
			wind_cmd_pkg::SOUTH_DELAY_CMD, wind_cmd_pkg::WEST_DELAY_CMD, wind_cmd_pkg::CONVERTER_KIND_CMD,
			wind_cmd_pkg::SPEED_FACTOR_CMD, wind_cmd_pkg::ANGLE_SPEED_CORR_CMD: begin
				need = wind_cmd_pkg::LEVEL_CONFIG;
			end
			wind_cmd_pkg::AUTO_OUTPUT_SELECT_CMD, wind_cmd_pkg::TEXT_BUFFER_CMD,
			wind_cmd_pkg::TELEGRAM_DEF_SAVE_CMD, wind_cmd_pkg::PIN_ID_SELECT_CMD: begin
				need = wind_cmd_pkg::LEVEL_USER;
			end
			default: begin
				need = wind_cmd_pkg::LEVEL_ENQUIRY;
			end
		endcase
	end

	always_comb begin
		ok = 1'b0;
		unique case (code)
			wind_cmd_pkg::DIRECTION_SWAP_CMD, wind_cmd_pkg::CONVERTER_KIND_CMD, wind_cmd_pkg::PIN_ID_SELECT_CMD: begin
				ok = param_q <= 16'h0001;
			end
			wind_cmd_pkg::EAST_DELAY_CMD, wind_cmd_pkg::NORTH_DELAY_CMD: begin
				ok = param_q <= wind_cmd_pkg::DELAY_EN_MAX;
			end
			wind_cmd_pkg::SOUTH_DELAY_CMD, wind_cmd_pkg::WEST_DELAY_CMD: begin
				ok = param_q <= wind_cmd_pkg::DELAY_SW_MAX;
			end
			wind_cmd_pkg::TELEGRAM_REQUEST_CMD: begin
				ok = param_q != 16'h0000 && param_q <= wind_cmd_pkg::TELEGRAM_MAX
					&& !wind_cmd_pkg::RESERVED_MASK[param_q[3:0] - 4'h1];
			end
			wind_cmd_pkg::AUTO_OUTPUT_SELECT_CMD: begin
				ok = param_q <= wind_cmd_pkg::TELEGRAM_MAX
					&& (param_q[4] || !wind_cmd_pkg::RESERVED_MASK[param_q[3:0] - 4'h1]);
			end
			wind_cmd_pkg::TELEGRAM_ITEM_APPEND_CMD: begin
				ok = items_q < ITEM_W'(wind_cmd_pkg::DROP_MAX);
			end
			wind_cmd_pkg::TELEGRAM_ITEM_DROP_CMD: begin
				ok = param_q <= wind_cmd_pkg::DROP_MAX && param_q[ITEM_W-1:0] <= items_q
					&& param_q[15:ITEM_W] == '0;
			end
			wind_cmd_pkg::TELEGRAM_DEF_SAVE_CMD: begin
				ok = param_q == wind_cmd_pkg::SAVE_PARAM;
			end
			wind_cmd_pkg::TELEGRAM_DEFINE_CMD: begin
				ok = param_q <= wind_cmd_pkg::DROP_MAX;
			end
			wind_cmd_pkg::TEXT_BUFFER_CMD: begin
				ok = param_q != 16'h0000 && param_q <= wind_cmd_pkg::TEXT_ENTRIES;
			end
			wind_cmd_pkg::SPEED_FACTOR_CMD: begin
				ok = param_q <= wind_cmd_pkg::FACTOR_MAX;
			end
			wind_cmd_pkg::ANGLE_SPEED_CORR_CMD: begin
				ok = param_q <= wind_cmd_pkg::ANGLE_MAX;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		if (level < need) begin
			ok = 1'b0;
		end
	end

	// Parameter and interval registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			param_q <= 16'h0000;
			interval_q <= wind_cmd_pkg::INTERVAL_RST;
		end else if (wr_pend_q) begin
			if (addr_q == wind_cmd_pkg::PARAM_OFF) begin
				param_q <= hwdata[15:0];
			end
			if (addr_q == wind_cmd_pkg::INTERVAL_OFF) begin
				interval_q <= hwdata[15:0];
			end
		end
	end

	// Outcome of the last command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			accepted_q <= 1'b0;
			rejected_q <= 1'b0;
		end else if (exec) begin
			accepted_q <= ok;
			rejected_q <= !ok;
		end
	end

	// Settings; reset values double as defaults, except converter_kind, loaded from CONV_KIND_INIT at start-up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			direction_swap <= 1'b0;
			converter_kind <= 1'b0;
			east_delay <= 12'h000;
			north_delay <= 12'h000;
			south_delay <= 13'h0000;
			west_delay <= 13'h0000;
			speed_factor <= wind_cmd_pkg::FACTOR_RST[10:0];
			angle_corr <= wind_cmd_pkg::ANGLE_RST;
			auto_sel_q <= 5'h00;
		end else if (boot_q == ST_BOOT) begin
			converter_kind <= CONV_KIND_INIT;
		end else if (exec && ok) begin
			unique case (code)
				wind_cmd_pkg::DIRECTION_SWAP_CMD: direction_swap <= param_q[0];
				wind_cmd_pkg::CONVERTER_KIND_CMD: converter_kind <= param_q[0];
				wind_cmd_pkg::EAST_DELAY_CMD: east_delay <= param_q[11:0];
				wind_cmd_pkg::NORTH_DELAY_CMD: north_delay <= param_q[11:0];
				wind_cmd_pkg::SOUTH_DELAY_CMD: south_delay <= param_q[12:0];
				wind_cmd_pkg::WEST_DELAY_CMD: west_delay <= param_q[12:0];
				wind_cmd_pkg::SPEED_FACTOR_CMD: speed_factor <= param_q[10:0];
				wind_cmd_pkg::ANGLE_SPEED_CORR_CMD: angle_corr <= param_q[1:0];
				wind_cmd_pkg::AUTO_OUTPUT_SELECT_CMD: auto_sel_q <= param_q[4:0];
				default: begin
				end
			endcase
		end
	end

	// User telegram definition count, volatile until saved
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			items_q <= '0;
			nv_item_count <= '0;
			nv_telegram_save <= 1'b0;
		end else begin
			nv_telegram_save <= 1'b0;
			if (exec && ok) begin
				unique case (code)
					wind_cmd_pkg::TELEGRAM_ITEM_APPEND_CMD: items_q <= items_q + ITEM_W'(1);
					wind_cmd_pkg::TELEGRAM_ITEM_DROP_CMD: items_q <= items_q - param_q[ITEM_W-1:0];
					wind_cmd_pkg::TELEGRAM_DEFINE_CMD: items_q <= param_q[ITEM_W-1:0];
					wind_cmd_pkg::TELEGRAM_DEF_SAVE_CMD: begin
						nv_item_count <= items_q;
						nv_telegram_save <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Text entry select and character write pointer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			text_idx_q <= 6'h00;
			text_pos_q <= 5'h00;
			text_raddr_q <= 10'h000;
		end else begin
			if (exec && ok && code == wind_cmd_pkg::TEXT_BUFFER_CMD) begin
				text_idx_q <= param_q[5:0];
				text_pos_q <= 5'h00;
			end else if (text_we) begin
				text_pos_q <= text_pos_q + 5'h01;
			end
			if (wr_pend_q && addr_q == wind_cmd_pkg::TEXT_RADDR_OFF) begin
				text_raddr_q <= hwdata[9:0];
			end
		end
	end

	// Writes past 32 characters wrap within the entry
	assign text_we = wr_pend_q && addr_q == wind_cmd_pkg::TEXT_CHAR_OFF && text_idx_q != 6'h00;

	text_mem #(
		.DEPTH(1024),
		.AW(10)
	) u_text (
		.hclk(hclk),
		.we(text_we),
		.waddr({text_idx_q[4:0] - 5'h01, text_pos_q}),
		.wdata(hwdata[7:0]),
		.raddr(text_raddr_q),
		.rdata(text_rdata)
	);

	// Millisecond enable for the output interval
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_cnt_q <= 32'h0000_0000;
		end else if (ms_tick) begin
			ms_cnt_q <= 32'h0000_0000;
		end else begin
			ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
		end
	end
	assign ms_tick = ms_cnt_q == 32'(MS_CYCLES - 1);

	// Zero selection stops the interval counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ivl_cnt_q <= 16'h0000;
		end else if (auto_sel_q == 5'h00) begin
			ivl_cnt_q <= 16'h0000;
		end else if (ms_tick) begin
			ivl_cnt_q <= (ivl_cnt_q + 16'h0001 >= interval_q) ? 16'h0000 : ivl_cnt_q + 16'h0001;
		end
	end

	// One telegram per request, next cycle well inside the reply limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			telegram_send <= 1'b0;
			telegram_num <= 5'h00;
		end else begin
			telegram_send <= 1'b0;
			if (exec && ok && code == wind_cmd_pkg::TELEGRAM_REQUEST_CMD) begin
				telegram_send <= 1'b1;
				telegram_num <= param_q[4:0];
			// Auto output of any selection including 6
			end else if (auto_sel_q != 5'h00 && ms_tick && ivl_cnt_q + 16'h0001 >= interval_q) begin
				telegram_send <= 1'b1;
				telegram_num <= auto_sel_q;
			end
		end
	end

	// Start-up ID capture, store and announce
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_q <= ST_BOOT;
			pin_id_sel_q <= 1'b0;
			instrument_id <= 3'h0;
			nv_id_write <= 1'b0;
			id_announce <= 1'b0;
		end else begin
			nv_id_write <= 1'b0;
			id_announce <= 1'b0;
			unique case (boot_q)
				ST_BOOT: begin
					pin_id_sel_q <= nv_pin_id_sel;
					instrument_id <= nv_pin_id_sel ? pin_id : nv_instrument_id;
					nv_id_write <= nv_pin_id_sel;
					boot_q <= nv_pin_id_sel ? ST_ANNOUNCE : ST_RUN;
				end
				ST_ANNOUNCE: begin
					id_announce <= 1'b1;
					boot_q <= ST_RUN;
				end
				ST_RUN: begin
					if (exec && ok && code == wind_cmd_pkg::PIN_ID_SELECT_CMD) begin
						pin_id_sel_q <= param_q[0];
					end
				end
			endcase
		end
	end

	// Read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (haddr[7:0])
				wind_cmd_pkg::PARAM_OFF: hrdata <= {16'h0000, param_q};
				wind_cmd_pkg::STATUS_OFF: hrdata <= {28'h000_0000, boot_q == ST_RUN, pin_id_sel_q, rejected_q, accepted_q};
				wind_cmd_pkg::CONFIG_OFF: hrdata <= {16'h0000, auto_sel_q, instrument_id, 3'h0,
					angle_corr, converter_kind, direction_swap, 1'b0};
				wind_cmd_pkg::DELAY_EN_OFF: hrdata <= {4'h0, north_delay, 4'h0, east_delay};
				wind_cmd_pkg::DELAY_SW_OFF: hrdata <= {3'h0, west_delay, 3'h0, south_delay};
				wind_cmd_pkg::FACTOR_OFF: hrdata <= {21'h00_0000, speed_factor};
				wind_cmd_pkg::INTERVAL_OFF: hrdata <= {16'h0000, interval_q};
				wind_cmd_pkg::TEXT_RADDR_OFF: hrdata <= {22'h00_0000, text_raddr_q};
				wind_cmd_pkg::TEXT_RDATA_OFF: hrdata <= {24'h00_0000, text_rdata};
				wind_cmd_pkg::ITEMS_OFF: hrdata <= {16'h0000, 2'h0, nv_item_count, 2'h0, items_q};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : wind_cmd_handler
`default_nettype wire

//--- wind_cmd_pkg.sv
// Purpose: Shared constants for the wind sensor command handler
// Assumes: AHB-Lite register access, 32-bit words
// Notes: Command codes and access levels are carried in the command register
package wind_cmd_pkg;
	// Register byte offsets
	localparam logic [7:0] CMD_OFF = 8'h00;
	localparam logic [7:0] PARAM_OFF = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] CONFIG_OFF = 8'h0C;
	localparam logic [7:0] DELAY_EN_OFF = 8'h10;
	localparam logic [7:0] DELAY_SW_OFF = 8'h14;
	localparam logic [7:0] FACTOR_OFF = 8'h18;
	localparam logic [7:0] INTERVAL_OFF = 8'h1C;
	localparam logic [7:0] TEXT_CHAR_OFF = 8'h20;
	localparam logic [7:0] TEXT_RADDR_OFF = 8'h24;
	localparam logic [7:0] TEXT_RDATA_OFF = 8'h28;
	localparam logic [7:0] ITEMS_OFF = 8'h2C;
	// Command register fields
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_LEVEL_LSB = 8;
	// Command codes
	localparam logic [4:0] DIRECTION_SWAP_CMD = 5'h01;
	localparam logic [4:0] EAST_DELAY_CMD = 5'h02;
	localparam logic [4:0] NORTH_DELAY_CMD = 5'h03;
	localparam logic [4:0] SOUTH_DELAY_CMD = 5'h04;
	localparam logic [4:0] WEST_DELAY_CMD = 5'h05;
	localparam logic [4:0] CONVERTER_KIND_CMD = 5'h06;
	localparam logic [4:0] TELEGRAM_REQUEST_CMD = 5'h07;
	localparam logic [4:0] AUTO_OUTPUT_SELECT_CMD = 5'h08;
	localparam logic [4:0] TELEGRAM_ITEM_APPEND_CMD = 5'h09;
	localparam logic [4:0] TELEGRAM_ITEM_DROP_CMD = 5'h0A;
	localparam logic [4:0] TELEGRAM_DEF_SAVE_CMD = 5'h0B;
	localparam logic [4:0] TELEGRAM_DEFINE_CMD = 5'h0C;
	localparam logic [4:0] TEXT_BUFFER_CMD = 5'h0D;
	localparam logic [4:0] SPEED_FACTOR_CMD = 5'h0E;
	localparam logic [4:0] ANGLE_SPEED_CORR_CMD = 5'h0F;
	localparam logic [4:0] PIN_ID_SELECT_CMD = 5'h10;
	// Access levels, higher grants lower
	localparam logic [1:0] LEVEL_ENQUIRY = 2'h0;
	localparam logic [1:0] LEVEL_USER = 2'h1;
	localparam logic [1:0] LEVEL_CONFIG = 2'h2;
	// Ranges
	localparam logic [15:0] DELAY_EN_MAX = 16'h0FFF;
	localparam logic [15:0] DELAY_SW_MAX = 16'h1000;
	localparam logic [15:0] TELEGRAM_MAX = 16'h0010;
	localparam logic [15:0] USER_TELEGRAM = 16'h0006;
	localparam logic [15:0] DROP_MAX = 16'h001E;
	localparam logic [15:0] SAVE_PARAM = 16'h0002;
	localparam logic [15:0] TEXT_ENTRIES = 16'h0020;
	localparam logic [15:0] FACTOR_MAX = 16'h07D0;
	localparam logic [15:0] ANGLE_MAX = 16'h0002;
	// Reserved telegram numbers
	localparam logic [15:0] RESERVED_MASK = 16'h5600;
	// Reset values
	localparam logic [15:0] FACTOR_RST = 16'h041F;
	localparam logic [1:0] ANGLE_RST = 2'h2;
	localparam logic [15:0] INTERVAL_RST = 16'h0001;
	// Timing
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_PER_S = 1000;
	localparam int REPLY_LIMIT_MS = 1;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
endpackage : wind_cmd_pkg

//--- text_mem.sv
// Purpose: User text store, one byte per location
// Assumes: single clock, registered read
// Notes: No reset on the array; contents undefined until written
`timescale 1ns/10ps
`default_nettype none
module text_mem #(
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	// Clock
	input wire logic hclk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem_q [DEPTH];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge hclk) begin
		rdata <= mem_q[raddr];
	end
endmodule : text_mem
`default_nettype wire

//--- wind_cmd_props.sv
// Purpose: Port checks for the command handler
// Assumes: one clock, async active-low reset
// Notes: Command writes are remembered for four cycles
`timescale 1ns/10ps
`default_nettype none
module wind_cmd_props (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	// ID lines
	input wire logic speed_out_rx_neg_line_n,
	input wire logic dir_out_rx_pos_line_n,
	input wire logic third_id_line_n,
	// Outputs
	input wire logic telegram_send,
	input wire logic [4:0] telegram_num,
	input wire logic nv_id_write,
	input wire logic id_announce,
	input wire logic nv_telegram_save,
	input wire logic [2:0] instrument_id,
	input wire logic direction_swap,
	input wire logic [11:0] east_delay,
	input wire logic [11:0] north_delay,
	input wire logic [12:0] south_delay,
	input wire logic [12:0] west_delay,
	input wire logic [10:0] speed_factor,
	input wire logic [1:0] angle_corr
);
	logic [3:0] cw_q;
	logic cmd_seen;
	// Settings may only move shortly after a command write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cw_q <= 4'h0;
		end else begin
			cw_q <= {cw_q[2:0], hsel & hready & htrans[1] & hwrite & (haddr[7:0] == wind_cmd_pkg::CMD_OFF)};
		end
	end
	assign cmd_seen = |cw_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_sw_range;
		south_delay <= 13'h1000 && west_delay <= 13'h1000;
	endproperty
	a_sw_range: assert property (p_sw_range) else $error("south or west delay out of range");
	property p_factor_range;
		speed_factor <= 11'h7D0;
	endproperty
	a_factor_range: assert property (p_factor_range) else $error("speed factor out of range");
	property p_angle_code;
		angle_corr != 2'h3;
	endproperty
	a_angle_code: assert property (p_angle_code) else $error("angle correction code invalid");
	property p_set_cause;
		!$stable({direction_swap, east_delay, north_delay, south_delay, west_delay, speed_factor, angle_corr})
			|-> cmd_seen;
	endproperty
	a_set_cause: assert property (p_set_cause) else $error("setting moved without a command");
	property p_send_num;
		telegram_send |-> telegram_num inside {[5'h01:5'h10]} && !wind_cmd_pkg::RESERVED_MASK[telegram_num - 5'h01];
	endproperty
	a_send_num: assert property (p_send_num) else $error("telegram number not sendable");
	property p_id_lines;
		nv_id_write |-> instrument_id == ~{third_id_line_n, dir_out_rx_pos_line_n, speed_out_rx_neg_line_n};
	endproperty
	a_id_lines: assert property (p_id_lines) else $error("stored ID differs from lines");
	property p_announce;
		nv_id_write |=> id_announce;
	endproperty
	a_announce: assert property (p_announce) else $error("ID store not announced");
	property p_save_cause;
		nv_telegram_save |-> cmd_seen;
	endproperty
	a_save_cause: assert property (p_save_cause) else $error("save without a command");
	c_user_tg: cover property (telegram_send && telegram_num == 5'h06);
	c_save: cover property (nv_telegram_save);
	c_announce: cover property (id_announce);
endmodule : wind_cmd_props
bind wind_cmd_handler wind_cmd_props wind_cmd_props_inst (.*);
`default_nettype wire

//--- nv_store_model.sv
// Purpose: Nonvolatile store and telegram sink beside the handler
// Assumes: store keeps its value through resets
// Notes: Counts sends so the bench can expect exact numbers
`timescale 1ns/10ps
`default_nettype none
module nv_store_model #(
	parameter logic [2:0] ID_INIT = 3'h5 // Arbitrary value
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Start-up values
	input wire logic use_pins,
	output logic nv_pin_id_sel,
	output logic [2:0] nv_instrument_id,
	// Requests
	input wire logic nv_id_write,
	input wire logic id_announce,
	input wire logic [2:0] instrument_id,
	input wire logic telegram_send,
	input wire logic [4:0] telegram_num
);
	int sends = 0;
	int announces = 0;
	logic [4:0] last_num = 5'h00;
	logic [2:0] stored_id = ID_INIT;
	assign nv_pin_id_sel = use_pins;
	assign nv_instrument_id = stored_id;
	always @(posedge hclk) begin
		if (nv_id_write) begin
			stored_id <= instrument_id;
		end
		if (id_announce) begin
			announces <= announces + 1;
		end
		if (telegram_send) begin
			sends <= sends + 1;
			last_num <= telegram_num;
		end
	end
endmodule : nv_store_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the command handler
// Assumes: zero-wait bus, short millisecond parameter
// Notes: Seeded random values mixed with boundary cases
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [2:0] id_n = 3'h5;
	logic use_pins = 1'b1;
	logic hready, hreadyout, hresp, telegram_send, nv_id_write, id_announce, nv_telegram_save;
	logic nv_pin_id_sel, direction_swap, converter_kind;
	logic [31:0] hrdata, r;
	logic [4:0] telegram_num;
	logic [5:0] nv_item_count;
	logic [2:0] nv_instrument_id, instrument_id;
	logic [11:0] east_delay, north_delay;
	logic [12:0] south_delay, west_delay;
	logic [10:0] speed_factor;
	logic [1:0] angle_corr;
	logic [15:0] v;
	int bad_count = 0;
	int checked = 0;
	int seed = 21;
	int k;
	logic [4:0] cfg_code [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0E, 5'h0F};
	logic [15:0] cfg_max [8] = '{16'h0001, 16'h0FFF, 16'h0FFF, 16'h1000, 16'h1000, 16'h0001, 16'h07D0, 16'h0002};
	logic [15:0] exp_v [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h041F, 16'h0002};
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	wind_cmd_handler #(.MS_CYCLES(10)) wind_cmd_handler_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .speed_out_rx_neg_line_n(id_n[0]),
		.dir_out_rx_pos_line_n(id_n[1]), .third_id_line_n(id_n[2]), .nv_pin_id_sel, .nv_instrument_id,
		.telegram_send, .telegram_num, .nv_id_write, .id_announce, .nv_telegram_save, .nv_item_count,
		.instrument_id, .direction_swap, .converter_kind, .east_delay, .north_delay, .south_delay, .west_delay,
		.speed_factor, .angle_corr);
	nv_store_model nv_store_model_inst (.hclk, .hresetn, .use_pins, .nv_pin_id_sel, .nv_instrument_id,
		.nv_id_write, .id_announce, .instrument_id, .telegram_send, .telegram_num);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr
	// Frame of one command: parameter, then code and level, then status
	task automatic cmd(input logic [4:0] c, input logic [1:0] l, input logic [15:0] p, input logic ok);
		logic [31:0] s;
		wr(wind_cmd_pkg::PARAM_OFF, {16'h0000, p});
		wr(wind_cmd_pkg::CMD_OFF, {22'h00_0000, l, 3'h0, c});
		ahb(1'b0, wind_cmd_pkg::STATUS_OFF, 32'h0000_0000, s);
		chk(32'(s[1:0]), ok ? 32'h0000_0001 : 32'h0000_0002);
	endtask : cmd
	function automatic logic [15:0] port_val(input int i);
		case (i)
			0: port_val = 16'(direction_swap);
			1: port_val = 16'(east_delay);
			2: port_val = 16'(north_delay);
			3: port_val = 16'(south_delay);
			4: port_val = 16'(west_delay);
			5: port_val = 16'(converter_kind);
			6: port_val = 16'(speed_factor);
			default: port_val = 16'(angle_corr);
		endcase
	endfunction : port_val
	// Telegram numbers that have a layout
	function automatic logic tg_ok(input int n);
		tg_ok = n inside {[1:9], 12, 14, 16};
	endfunction : tg_ok
	task automatic tally_and_finish();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (30000) @(posedge hclk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(32'(instrument_id), 32'h0000_0002);
		chk(32'(nv_store_model_inst.stored_id), 32'h0000_0002);
		chk(nv_store_model_inst.announces, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			v = 16'(r % (32'(cfg_max[i]) + 32'h1));
			chk(32'(port_val(i)), 32'(exp_v[i]));
			cmd(cfg_code[i], 2'h1, v, 1'b0);
			cmd(cfg_code[i], 2'h2, v, 1'b1);
			chk(32'(port_val(i)), 32'(v));
			cmd(cfg_code[i], 2'h2, cfg_max[i] + 16'h0001, 1'b0);
			chk(32'(port_val(i)), 32'(v));
			cmd(cfg_code[i], 2'h2, cfg_max[i], 1'b1);
			chk(32'(port_val(i)), 32'(cfg_max[i]));
		end
		// Auto output is still off, so every send here is a reply
		for (int n = 0; n <= 17; n++) begin
			k = nv_store_model_inst.sends;
			cmd(5'h07, 2'h0, 16'(n), tg_ok(n));
			repeat (2) @(posedge hclk);
			chk(nv_store_model_inst.sends - k, 32'(tg_ok(n)));
			if (tg_ok(n)) chk(32'(nv_store_model_inst.last_num), n);
		end
		cmd(5'h0C, 2'h0, 16'h0005, 1'b1);
		cmd(5'h09, 2'h0, 16'h0000, 1'b1);
		cmd(5'h0A, 2'h0, 16'h0002, 1'b1);
		cmd(5'h0A, 2'h0, 16'h001F, 1'b0);
		cmd(5'h0B, 2'h0, 16'h0002, 1'b0);
		cmd(5'h0B, 2'h1, 16'h0001, 1'b0);
		cmd(5'h0B, 2'h1, 16'h0002, 1'b1);
		cmd(5'h0C, 2'h0, 16'h001E, 1'b1);
		cmd(5'h09, 2'h0, 16'h0000, 1'b0);
		ahb(1'b0, wind_cmd_pkg::ITEMS_OFF, 32'h0000_0000, r);
		chk(r, 32'h0000_041E);
		chk(32'(nv_item_count), 32'h0000_0004);
		wr(wind_cmd_pkg::INTERVAL_OFF, 32'h0000_0001);
		cmd(5'h08, 2'h0, 16'h0006, 1'b0);
		cmd(5'h08, 2'h1, 16'h0011, 1'b0);
		cmd(5'h08, 2'h1, 16'h0006, 1'b1);
		k = nv_store_model_inst.sends;
		repeat (100) @(posedge hclk);
		k = nv_store_model_inst.sends - k;
		chk(32'(k >= 9 && k <= 11), 32'h0000_0001);
		chk(32'(nv_store_model_inst.last_num), 32'h0000_0006);
		cmd(5'h08, 2'h1, 16'h0000, 1'b1);
		k = nv_store_model_inst.sends;
		repeat (100) @(posedge hclk);
		chk(nv_store_model_inst.sends - k, 32'h0000_0000);
		cmd(5'h0D, 2'h1, 16'h0000, 1'b0);
		cmd(5'h0D, 2'h1, 16'h0021, 1'b0);
		r = $random(seed);
		v = 16'(r[4:0]) + 16'h0001;
		cmd(5'h0D, 2'h1, v, 1'b1);
		wr(wind_cmd_pkg::TEXT_CHAR_OFF, 32'h0000_0041);
		wr(wind_cmd_pkg::TEXT_CHAR_OFF, {24'h00_0000, r[15:8]});
		wr(wind_cmd_pkg::TEXT_RADDR_OFF, 32'((v - 16'h0001) * 16'h0020 + 16'h0001));
		repeat (2) @(posedge hclk);
		ahb(1'b0, wind_cmd_pkg::TEXT_RDATA_OFF, 32'h0000_0000, k);
		chk(k & 32'h0000_00FF, 32'(r[15:8]));
		cmd(5'h10, 2'h1, 16'h0000, 1'b1);
		cmd(5'h10, 2'h0, 16'h0001, 1'b0);
		cmd(5'h10, 2'h1, 16'h0002, 1'b0);
		cmd(5'h10, 2'h1, 16'h0001, 1'b1);
		ahb(1'b0, wind_cmd_pkg::STATUS_OFF, 32'h0000_0000, r);
		chk(32'(r[2]), 32'h0000_0001);
		wr(8'h3C, 32'h0000_FFFF);
		ahb(1'b0, 8'h3C, 32'h0000_0000, r);
		chk(r, 32'h0000_0000);
		chk(32'(hresp), 32'h0000_0000);
		// Lines change but the stored ID must win after this reset
		id_n <= 3'h3;
		use_pins <= 1'b0;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk(32'(instrument_id), 32'h0000_0002);
		chk(nv_store_model_inst.announces, 32'h0000_0001);
		chk(32'(speed_factor), 32'h0000_041F);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
